// ===== hdl/flash_code_security_lock.sv
// Functional notes
// - three-bit hardware lock field, programmed bit reads zero, four levels
// - level two up: external code-table reads cannot fetch internal code
// - level two up: access pin latched at reset, later changes ignored
// - level two up: parallel programming refused; in-system and API still allowed
// - level three up: parallel verify reads of code refused
// - level four: external execution forbidden; delivered default is level four
// - chip erase clears flash and returns hardware byte to unprotected state
// - part reference readable over parallel path at any level
// - delivered hardware byte: boot jump programmed, standard speed, ram valid
// - extra-flash defaults: boot vector FCh, boot status FFh, security FFh
// - software level two: in-system programming writes refused
// - software level three: in-system verify reads also refused
// - among commands, hardware lock gates parallel path only; software byte gates in-system
// - parallel protection needs the hardware field; software byte alone gives none
// - extra-flash registers reachable from parallel, in-system and API commands
// - access pin high: fetch from internal flash
// - access pin low: every fetch from external memory
// - boot jump bit zero starts loader at F800h, one starts 0000h
`timescale 1ns/1ps
`default_nettype none

module flash_code_security_lock
  import fcs_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter logic [7:0] REF_CODE0 = 8'h11, // arbitrary value
  parameter logic [7:0] REF_CODE1 = 8'h22, // arbitrary value
  parameter logic [7:0] REF_CODE2 = 8'h33, // arbitrary value
  parameter logic [7:0] REF_CODE3 = 8'h44 // arbitrary value
)
(
  input wire logic mclk, // core clock
  input wire logic rst_n, // async reset, active low
  input wire logic extAccessPin, // external access pin, high = internal
  input wire logic cmdReq, // command request pulse
  input wire logic [1:0] cmdSrc, // 0 parallel, 1 in-system, 2 api
  input wire logic [2:0] cmdOp, // command code
  input wire logic [ADDR_W-1:0] cmdAddr, // code or extra-flash address
  input wire logic [7:0] cmdWrData, // write data
  output logic cmdAck, // answer pulse
  output logic cmdRefused, // answer was a refusal
  output logic [7:0] cmdRdData, // read data
  output logic eraseBusy, // chip erase in progress
  input wire logic fetchReq, // processor fetch request
  input wire logic [ADDR_W-1:0] fetchAddr, // fetch address
  input wire logic fetchTableRead, // fetch is a code-table read
  input wire logic fetchFromExt, // requesting code runs from external memory
  output logic fetchValid, // fetch answered
  output logic fetchInternal, // answer comes from internal flash
  output logic fetchBlocked, // fetch refused by protection
  output logic [7:0] fetchData, // internal byte, zero when blocked or external
  output logic [15:0] bootAddr, // start address after reset
  output logic doubleSpeed, // double speed mode selected
  output logic xramValid, // expanded ram valid
  output logic [2:0] hwLevel, // hardware level latched at reset
  output logic [2:0] swLevel // software level
);

  // ***********************************************
  // storage
  // ***********************************************
  localparam int DEPTH = 2 ** ADDR_W;
  logic [7:0] codeMem [DEPTH];
  logic [7:0] hsb_q, hsb_d;
  logic [7:0] sbv_q, sbv_d;
  logic [7:0] bsb_q, bsb_d;
  logic [7:0] ssb_q, ssb_d;
  fcs_state_t state_q, state_d;
  logic [ADDR_W-1:0] eraseAddr_q, eraseAddr_d;
  logic [2:0] hwLevel_q, swLevel_q;
  logic eaLatched_q;
  logic [15:0] bootAddr_q;
  logic doubleSpeed_q, xramValid_q, eraseBusy_q;
  logic ack_q, refused_q;
  logic [7:0] rdData_q, rdData_d;
  logic fValid_q, fInternal_q, fBlocked_q;
  logic [7:0] fData_q;

  fcs_lvl_if lvl ();

  fcs_level_decode u_dec (
    .lvl(lvl)
  );

  assign lvl.hwLock = hsb_q[HSB_LOCK_LSB +: 3];
  assign lvl.swLock = ssb_q[SSB_LOCK_LSB +: 2];

  // ***********************************************
  // command decode
  // ***********************************************
  fcs_cmd_t op;
  fcs_src_t src;
  assign op = fcs_cmd_t'(cmdOp);
  assign src = fcs_src_t'(cmdSrc);

  wire running = (state_q == ST_RUN);
  wire take = cmdReq && running;
  wire isPar = (src == SRC_PAR);
  wire isIsp = (src == SRC_ISP);
  wire [2:0] xafIdx = cmdAddr[2:0];

  // parallel follows only the hardware level taken at reset, in-system only
  // the software byte, api code reads and writes are not gated
  wire parWr = (hwLevel_q < LVL_2);
  wire parVf = (hwLevel_q < LVL_3);
  wire codeWrOk = isPar ? parWr : (isIsp ? lvl.ispWriteOk : 1'b1);
  wire codeRdOk = isPar ? parVf : (isIsp ? lvl.ispVerifyOk : 1'b1);

  // hardware byte is only reachable from the parallel programmer
  wire hsbOk = isPar;
  wire xafWrOk = (xafIdx == XAF_SBV) || (xafIdx == XAF_BSB) || (xafIdx == XAF_SSB);

  wire doWrCode = take && (op == CMD_WR_CODE) && codeWrOk;
  wire doWrXaf = take && (op == CMD_WR_XAF) && xafWrOk;
  wire doWrHsb = take && (op == CMD_WR_HSB) && hsbOk;
  wire doErase = take && (op == CMD_ERASE) && isPar;

  logic refuse;
  always_comb
  begin
    refuse = 1'b0;
    if (!running)
      refuse = 1'b1;
    else
    begin
      case (op)
        CMD_RD_CODE: refuse = !codeRdOk;
        CMD_WR_CODE: refuse = !codeWrOk;
        CMD_ERASE: refuse = !isPar;
        CMD_RD_REF: refuse = 1'b0;
        CMD_RD_XAF: refuse = 1'b0;
        CMD_WR_XAF: refuse = !xafWrOk;
        CMD_RD_HSB: refuse = !hsbOk;
        CMD_WR_HSB: refuse = !hsbOk;
        default: refuse = 1'b1;
      endcase
    end
  end

  // ***********************************************
  // read data selection
  // ***********************************************
  function automatic logic [7:0] refByte(input logic [1:0] idx);
    case (idx)
      2'h0: refByte = REF_CODE0;
      2'h1: refByte = REF_CODE1;
      2'h2: refByte = REF_CODE2;
      default: refByte = REF_CODE3;
    endcase
  endfunction : refByte

  logic [7:0] xafByte;
  always_comb
  begin
    case (xafIdx)
      XAF_SBV: xafByte = sbv_q;
      XAF_BSB: xafByte = bsb_q;
      XAF_SSB: xafByte = ssb_q;
      default: xafByte = (xafIdx >= XAF_REF0) ? refByte(xafIdx[1:0]) : 8'h00;
    endcase
  end

  always_comb
  begin
    rdData_d = 8'h00;
    if (take && !refuse)
    begin
      case (op)
        CMD_RD_CODE: rdData_d = codeMem[cmdAddr];
        CMD_RD_REF: rdData_d = refByte(xafIdx[1:0]);
        CMD_RD_XAF: rdData_d = xafByte;
        CMD_RD_HSB: rdData_d = hsb_q;
        default: rdData_d = 8'h00;
      endcase
    end
  end

  // ***********************************************
  // non-volatile register updates
  // ***********************************************
  // programming can only clear hardware bits; only a chip erase sets them
  assign hsb_d = doErase ? HSB_ERASED : (doWrHsb ? (hsb_q & cmdWrData) : hsb_q);
  // reserved security bits are stored as written; keeping them high is the writer's job
  assign ssb_d = doErase ? SSB_RESET :
                 ((doWrXaf && xafIdx == XAF_SSB) ? cmdWrData : ssb_q);
  assign sbv_d = (doWrXaf && xafIdx == XAF_SBV) ? cmdWrData : sbv_q;
  assign bsb_d = (doWrXaf && xafIdx == XAF_BSB) ? cmdWrData : bsb_q;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hsb_q <= HSB_RESET;
      sbv_q <= SBV_RESET;
      bsb_q <= BSB_RESET;
      ssb_q <= SSB_RESET;
      swLevel_q <= LVL_1;
    end
    else
    begin
      hsb_q <= hsb_d;
      sbv_q <= sbv_d;
      bsb_q <= bsb_d;
      ssb_q <= ssb_d;
      swLevel_q <= swLevelOf(ssb_d[SSB_LOCK_LSB +: 2]);
    end
  end

  // ***********************************************
  // state machine: reset capture, run, erase sweep
  // ***********************************************
  // the sweep takes one cycle per byte; commands are refused meanwhile
  always_comb
  begin
    state_d = state_q;
    eraseAddr_d = eraseAddr_q;
    case (state_q)
      ST_INIT: state_d = ST_RUN;
      ST_RUN:
      begin
        if (doErase)
        begin
          state_d = ST_ERASE;
          eraseAddr_d = '0;
        end
      end
      ST_ERASE:
      begin
        eraseAddr_d = eraseAddr_q + 1'b1;
        if (&eraseAddr_q)
          state_d = ST_RUN;
      end
      default: state_d = ST_INIT;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= ST_INIT;
      eraseAddr_q <= '0;
      eraseBusy_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      eraseAddr_q <= eraseAddr_d;
      eraseBusy_q <= (state_d == ST_ERASE);
    end
  end

  // memory has no reset; erase writes the blank value across the array
  wire memWe = (state_q == ST_ERASE) || doWrCode;
  wire [ADDR_W-1:0] memWa = (state_q == ST_ERASE) ? eraseAddr_q : cmdAddr;
  wire [7:0] memWd = (state_q == ST_ERASE) ? ERASED_BYTE : cmdWrData;

  always_ff @(posedge mclk)
  begin
    if (memWe)
      codeMem[memWa] <= memWd;
  end

  // ***********************************************
  // values caught once after reset release
  // ***********************************************
  wire capture = (state_q == ST_INIT);
  wire bootJump = hsb_q[HSB_BOOT_JUMP_BIT];

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hwLevel_q <= LVL_4;
      eaLatched_q <= 1'b0;
      bootAddr_q <= BOOT_LOADER_ADDR;
      doubleSpeed_q <= 1'b0;
      xramValid_q <= 1'b1;
    end
    else if (capture)
    begin
      hwLevel_q <= lvl.hwLevel;
      eaLatched_q <= extAccessPin;
      bootAddr_q <= bootJump ? APP_START_ADDR : BOOT_LOADER_ADDR;
      doubleSpeed_q <= !hsb_q[HSB_DOUBLE_SPEED_BIT];
      xramValid_q <= hsb_q[HSB_EXPANDED_RAM_VALID_BIT_VALID_BIT];
    end
  end

  // ***********************************************
  // command answer
  // ***********************************************
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_q <= 1'b0;
      refused_q <= 1'b0;
      rdData_q <= 8'h00;
    end
    else
    begin
      ack_q <= cmdReq;
      refused_q <= cmdReq && refuse;
      rdData_q <= rdData_d;
    end
  end

  // ***********************************************
  // processor fetch path
  // ***********************************************
  // below level two the pin is followed live
  wire eaUsed = (hwLevel_q >= LVL_2) ? eaLatched_q : extAccessPin;
  wire fromInternal = eaUsed;
  wire tableBlock = fetchTableRead && fetchFromExt && fromInternal &&
                    (hwLevel_q >= LVL_2);
  wire extExecBlock = !fromInternal && !fetchTableRead && (hwLevel_q == LVL_4);
  wire fBlock = tableBlock || extExecBlock;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fValid_q <= 1'b0;
      fInternal_q <= 1'b0;
      fBlocked_q <= 1'b0;
      fData_q <= 8'h00;
    end
    else
    begin
      fValid_q <= fetchReq && running;
      fInternal_q <= fetchReq && running && fromInternal;
      fBlocked_q <= fetchReq && running && fBlock;
      fData_q <= (fetchReq && running && fromInternal && !fBlock) ?
                 codeMem[fetchAddr] : 8'h00;
    end
  end

  // ***********************************************
  // outputs
  // ***********************************************
  assign cmdAck = ack_q;
  assign cmdRefused = refused_q;
  assign cmdRdData = rdData_q;
  assign eraseBusy = eraseBusy_q;
  assign fetchValid = fValid_q;
  assign fetchInternal = fInternal_q;
  assign fetchBlocked = fBlocked_q;
  assign fetchData = fData_q;
  assign bootAddr = bootAddr_q;
  assign doubleSpeed = doubleSpeed_q;
  assign xramValid = xramValid_q;
  assign hwLevel = hwLevel_q;
  assign swLevel = swLevel_q;

endmodule : flash_code_security_lock

`default_nettype wire

// ===== hdl/fcs_pkg.sv
package fcs_pkg;

  // ***********************************************
  // request sources and commands
  // ***********************************************
  typedef enum logic [1:0] {SRC_PAR, SRC_ISP, SRC_API} fcs_src_t;
  typedef enum logic [2:0] {
    CMD_RD_CODE, CMD_WR_CODE, CMD_ERASE, CMD_RD_REF,
    CMD_RD_XAF, CMD_WR_XAF, CMD_RD_HSB, CMD_WR_HSB
  } fcs_cmd_t;
  typedef enum {ST_INIT, ST_RUN, ST_ERASE} fcs_state_t;

  // ***********************************************
  // protection levels
  // ***********************************************
  localparam logic [2:0] LVL_1 = 3'h1;
  localparam logic [2:0] LVL_2 = 3'h2;
  localparam logic [2:0] LVL_3 = 3'h3;
  localparam logic [2:0] LVL_4 = 3'h4;

  // ***********************************************
  // hardware security byte layout and values
  // ***********************************************
  localparam int HSB_DOUBLE_SPEED_BIT = 7;
  localparam int HSB_BOOT_JUMP_BIT = 6;
  localparam int HSB_EXPANDED_RAM_VALID_BIT_VALID_BIT = 3;
  localparam int HSB_LOCK_LSB = 0;
  localparam logic [7:0] HSB_RESET = 8'hB8;
  localparam logic [7:0] HSB_ERASED = 8'hFF;

  // ***********************************************
  // extra flash array indices and values
  // ***********************************************
  localparam logic [2:0] XAF_SBV = 3'h0;
  localparam logic [2:0] XAF_BSB = 3'h1;
  localparam logic [2:0] XAF_SSB = 3'h2;
  localparam logic [2:0] XAF_REF0 = 3'h4;
  localparam logic [7:0] SBV_RESET = 8'hFC;
  localparam logic [7:0] BSB_RESET = 8'hFF;
  localparam logic [7:0] SSB_RESET = 8'hFF;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam int SSB_LOCK_LSB = 0;

  // ***********************************************
  // boot addresses
  // ***********************************************
  localparam logic [15:0] BOOT_LOADER_ADDR = 16'hF800;
  localparam logic [15:0] APP_START_ADDR = 16'h0000;

  // ***********************************************
  // lock field decoding
  // ***********************************************
  function automatic logic [2:0] hwLevelOf(input logic [2:0] lock);
    if (!lock[2])
      hwLevelOf = LVL_4;
    else if (!lock[1])
      hwLevelOf = LVL_3;
    else if (!lock[0])
      hwLevelOf = LVL_2;
    else
      hwLevelOf = LVL_1;
  endfunction : hwLevelOf

  function automatic logic [2:0] swLevelOf(input logic [1:0] lock);
    if (!lock[1])
      swLevelOf = LVL_3;
    else if (!lock[0])
      swLevelOf = LVL_2;
    else
      swLevelOf = LVL_1;
  endfunction : swLevelOf

endpackage : fcs_pkg

// ===== hdl/fcs_lvl_if.sv
`timescale 1ns/1ps
`default_nettype none

interface fcs_lvl_if;
  logic [2:0] hwLock;
  logic [1:0] swLock;
  logic [2:0] hwLevel;
  logic [2:0] swLevel;
  logic parWriteOk;
  logic parVerifyOk;
  logic ispWriteOk;
  logic ispVerifyOk;
  modport dec (input hwLock, swLock,
               output hwLevel, swLevel, parWriteOk, parVerifyOk, ispWriteOk, ispVerifyOk);
  modport use_ (output hwLock, swLock,
                input hwLevel, swLevel, parWriteOk, parVerifyOk, ispWriteOk, ispVerifyOk);
endinterface : fcs_lvl_if

`default_nettype wire

// ===== hdl/fcs_level_decode.sv
`timescale 1ns/1ps
`default_nettype none

module fcs_level_decode
  import fcs_pkg::*;
(
  fcs_lvl_if.dec lvl // lock fields in, levels and permissions out
);

  // the most restrictive level wins when several bits are programmed
  assign lvl.hwLevel = hwLevelOf(lvl.hwLock);
  assign lvl.swLevel = swLevelOf(lvl.swLock);
  assign lvl.parWriteOk = (lvl.hwLevel < LVL_2);
  assign lvl.parVerifyOk = (lvl.hwLevel < LVL_3);
  assign lvl.ispWriteOk = (lvl.swLevel < LVL_2);
  assign lvl.ispVerifyOk = (lvl.swLevel < LVL_3);

endmodule : fcs_level_decode

`default_nettype wire

// ===== dv/fcs_checker_properties.sv
`timescale 1ns/1ps
`default_nettype none

module fcs_checker
  import fcs_pkg::*;
(
  input wire logic mclk, // clock
  input wire logic rst_n, // reset
  input wire logic cmdReq, // request
  input wire logic [1:0] cmdSrc, // source
  input wire logic [2:0] cmdOp, // command
  input wire logic cmdAck, // answer
  input wire logic cmdRefused, // refusal
  input wire logic [7:0] cmdRdData, // read data
  input wire logic eraseBusy, // erase sweep
  input wire logic fetchReq, // fetch request
  input wire logic fetchTableRead, // table read
  input wire logic fetchFromExt, // code runs outside
  input wire logic fetchValid, // fetch answer
  input wire logic fetchInternal, // internal source
  input wire logic fetchBlocked, // fetch refused
  input wire logic [7:0] fetchData, // fetched byte
  input wire logic [2:0] hwLevel, // hardware level
  input wire logic [2:0] swLevel // software level
);
  // ****************************************
  // helper: the first edge after reset only captures levels
  // ****************************************
  logic upQ;
  logic runOk;

  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      upQ <= 1'h0;
    else
      upQ <= 1'h1;

  assign runOk = upQ && !eraseBusy;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_ack_follows_req: assert property (cmdReq |=> cmdAck)
    else $error("command not answered");
  a_par_write_lock: assert property (cmdReq && cmdSrc == SRC_PAR && cmdOp == CMD_WR_CODE
    && hwLevel >= LVL_2 |=> cmdRefused) else $error("parallel write not refused");
  a_par_verify_lock: assert property (cmdReq && cmdSrc == SRC_PAR && cmdOp == CMD_RD_CODE
    && hwLevel >= LVL_3 |=> cmdRefused && cmdRdData == 8'h00) else $error("verify not refused");
  a_ref_readable: assert property (runOk && cmdReq && cmdSrc == SRC_PAR
    && cmdOp == CMD_RD_REF |=> cmdAck && !cmdRefused) else $error("reference refused");
  a_isp_write_lock: assert property (cmdReq && cmdSrc == SRC_ISP && cmdOp == CMD_WR_CODE
    && swLevel >= LVL_2 |=> cmdRefused) else $error("in-system write not refused");
  a_isp_verify_lock: assert property (cmdReq && cmdSrc == SRC_ISP && cmdOp == CMD_RD_CODE
    && swLevel == LVL_3 |=> cmdRefused) else $error("in-system verify not refused");
  a_api_ungated: assert property (runOk && cmdReq && cmdSrc == SRC_API
    && cmdOp inside {CMD_RD_CODE, CMD_WR_CODE} |=> !cmdRefused) else $error("api refused");
  a_table_read_block: assert property (fetchReq && fetchTableRead && fetchFromExt
    && hwLevel >= LVL_2 ##1 fetchValid && fetchInternal |-> fetchBlocked && fetchData == 8'h00)
    else $error("table read leaked");
  a_ext_exec_block: assert property (fetchValid && !fetchInternal && !$past(fetchTableRead)
    && hwLevel == LVL_4 |-> fetchBlocked) else $error("external execution allowed");
  a_level_latched: assert property (upQ && $past(upQ) |-> $stable(hwLevel))
    else $error("hardware level changed");

  c_erase: cover property (cmdReq && cmdOp == CMD_ERASE ##1 eraseBusy);
  c_refused: cover property (cmdAck && cmdRefused);
  c_blocked: cover property (fetchValid && fetchBlocked);
endmodule : fcs_checker

bind flash_code_security_lock fcs_checker i_chk (.mclk, .rst_n, .cmdReq, .cmdSrc, .cmdOp,
  .cmdAck, .cmdRefused, .cmdRdData, .eraseBusy, .fetchReq, .fetchTableRead, .fetchFromExt,
  .fetchValid, .fetchInternal, .fetchBlocked, .fetchData, .hwLevel, .swLevel);

`default_nettype wire

// ===== dv/fcs_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module fcs_host_model
  import fcs_pkg::*;
#(
  parameter int ADDR_W = 4
)
(
  input wire logic mclk, // clock
  input wire logic cmdAck, // answer
  input wire logic cmdRefused, // refusal
  input wire logic [7:0] cmdRdData, // read data
  output logic cmdReq, // request
  output logic [1:0] cmdSrc, // source
  output logic [2:0] cmdOp, // command
  output logic [ADDR_W-1:0] cmdAddr, // address
  output logic [7:0] cmdWrData // write data
);
  // ****************************************
  // programmer / in-system host
  // ****************************************
  initial
  begin
    cmdReq = 1'h0;
    cmdSrc = 2'h0;
    cmdOp = 3'h0;
    cmdAddr = '0;
    cmdWrData = 8'h00;
  end

  task automatic issue(input fcs_src_t s, input fcs_cmd_t op, input logic [ADDR_W-1:0] a,
                       input logic [7:0] wd, output logic r, output logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    cmdReq <= 1'h1;
    cmdSrc <= s;
    cmdOp <= op;
    cmdAddr <= a;
    cmdWrData <= (op == CMD_WR_XAF && a[2:0] == XAF_SSB) ? (wd | 8'hFC) : wd;
    @(posedge mclk);
    cmdReq <= 1'h0;
    // released lines must not keep looking valid
    cmdAddr <= ~a;
    cmdWrData <= ~wd;
    @(negedge mclk);
    while (cmdAck !== 1'h1 && n < 4)
    begin
      n++;
      @(negedge mclk);
    end
    r = cmdRefused;
    d = cmdRdData;
  endtask : issue
endmodule : fcs_host_model

`default_nettype wire

// ===== dv/test_flash_code_security_lock.sv
`timescale 1ns/1ps
`default_nettype none

module test_flash_code_security_lock
  import fcs_pkg::*;
;
  localparam int AW = 4;
  localparam logic [7:0] REFS [4] = '{8'h5A, 8'h6B, 8'h7C, 8'h8D}; // arbitrary values
  logic mclk, rst_n, extAccessPin, cmdReq, cmdAck, cmdRefused, eraseBusy, fetchReq;
  logic fetchTableRead, fetchFromExt, fetchValid, fetchInternal, fetchBlocked;
  logic doubleSpeed, xramValid;
  logic [1:0] cmdSrc;
  logic [2:0] cmdOp, hwLevel, swLevel;
  logic [AW-1:0] cmdAddr, fetchAddr;
  logic [7:0] cmdWrData, cmdRdData, fetchData;
  logic [15:0] bootAddr;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;

  flash_code_security_lock #(.ADDR_W(AW), .REF_CODE0(REFS[0]), .REF_CODE1(REFS[1]),
    .REF_CODE2(REFS[2]), .REF_CODE3(REFS[3])) i_dut (.mclk, .rst_n, .extAccessPin, .cmdReq,
    .cmdSrc, .cmdOp, .cmdAddr, .cmdWrData, .cmdAck, .cmdRefused, .cmdRdData, .eraseBusy,
    .fetchReq, .fetchAddr, .fetchTableRead, .fetchFromExt, .fetchValid, .fetchInternal,
    .fetchBlocked, .fetchData, .bootAddr, .doubleSpeed, .xramValid, .hwLevel, .swLevel);

  fcs_host_model #(.ADDR_W(AW)) i_host (.mclk, .cmdAck, .cmdRefused, .cmdRdData, .cmdReq,
    .cmdSrc, .cmdOp, .cmdAddr, .cmdWrData);

  // ****************************************
  // clock, timeout and tasks
  // ****************************************
  always #50 mclk = ~mclk;

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      num_errors++;
      complete_run();
    end
  end

  task automatic complete_run;
    if (num_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val

  task automatic cmd(input fcs_src_t s, input fcs_cmd_t op, input logic [2:0] a,
                     input logic [7:0] wd, input logic eRef, input logic [7:0] eRd);
    logic r;
    logic [7:0] d;
    i_host.issue(s, op, AW'(a), wd, r, d);
    // an answer that never came shows up here as a missing acknowledge
    chk_val({15'h0000, cmdAck}, 16'h0001);
    chk_val({15'h0000, r}, {15'h0000, eRef});
    chk_val({8'h00, d}, {8'h00, eRd});
  endtask : cmd

  task automatic fetch(input logic [AW-1:0] a, input logic tbl, input logic fe,
                       input logic eInt, input logic eBlk, input logic [7:0] eD);
    @(posedge mclk);
    fetchReq <= 1'h1;
    fetchAddr <= a;
    fetchTableRead <= tbl;
    fetchFromExt <= fe;
    @(posedge mclk);
    fetchReq <= 1'h0;
    @(negedge mclk);
    chk_val({13'h0000, fetchValid, fetchInternal, fetchBlocked}, {13'h0000, 1'h1, eInt, eBlk});
    chk_val({8'h00, fetchData}, {8'h00, eD});
  endtask : fetch

  task automatic do_reset(input logic pin);
    @(posedge mclk);
    rst_n <= 1'h0;
    extAccessPin <= pin;
    repeat (10) @(posedge mclk);
    rst_n <= 1'h1;
    repeat (2) @(posedge mclk);
  endtask : do_reset

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    mclk = 1'h0;
    rst_n = 1'h0;
    extAccessPin = 1'h1;
    fetchReq = 1'h0;
    fetchAddr = '0;
    fetchTableRead = 1'h0;
    fetchFromExt = 1'h0;
    do_reset(1'h1);
    chk_val({13'h0000, hwLevel}, {13'h0000, LVL_4});
    chk_val(bootAddr, 16'hF800);
    chk_val({14'h0000, doubleSpeed, xramValid}, 16'h0001);
    cmd(SRC_PAR, CMD_RD_HSB, 3'h0, 8'h00, 1'h0, 8'hB8);
    cmd(SRC_PAR, CMD_RD_XAF, XAF_SBV, 8'h00, 1'h0, 8'hFC);
    cmd(SRC_ISP, CMD_RD_XAF, XAF_BSB, 8'h00, 1'h0, 8'hFF);
    cmd(SRC_API, CMD_RD_XAF, XAF_SSB, 8'h00, 1'h0, 8'hFF);
    for (int i = 0; i < 4; i++)
      cmd(SRC_PAR, CMD_RD_REF, 3'(i), 8'h00, 1'h0, REFS[i]);
    cmd(SRC_PAR, CMD_WR_CODE, 3'h3, 8'h5A, 1'h1, 8'h00);
    cmd(SRC_PAR, CMD_RD_CODE, 3'h3, 8'h00, 1'h1, 8'h00);
    cmd(SRC_ISP, CMD_WR_CODE, 3'h3, 8'h5A, 1'h0, 8'h00);
    cmd(SRC_ISP, CMD_RD_CODE, 3'h3, 8'h00, 1'h0, 8'h5A);
    cmd(SRC_API, CMD_WR_CODE, 3'h4, 8'hC3, 1'h0, 8'h00);
    cmd(SRC_API, CMD_RD_CODE, 3'h4, 8'h00, 1'h0, 8'hC3);
    cmd(SRC_ISP, CMD_WR_XAF, XAF_BSB, 8'h00, 1'h0, 8'h00);
    cmd(SRC_PAR, CMD_RD_XAF, XAF_BSB, 8'h00, 1'h0, 8'h00);
    fetch(4'h3, 1'h0, 1'h0, 1'h1, 1'h0, 8'h5A);
    @(posedge mclk);
    extAccessPin <= 1'h0;
    fetch(4'h3, 1'h0, 1'h0, 1'h1, 1'h0, 8'h5A);
    fetch(4'h4, 1'h1, 1'h1, 1'h1, 1'h1, 8'h00);
    fetch(4'h4, 1'h1, 1'h0, 1'h1, 1'h0, 8'hC3);
    cmd(SRC_ISP, CMD_WR_XAF, XAF_SSB, 8'hFE, 1'h0, 8'h00);
    chk_val({13'h0000, swLevel}, {13'h0000, LVL_2});
    cmd(SRC_ISP, CMD_WR_CODE, 3'h5, 8'h77, 1'h1, 8'h00);
    cmd(SRC_ISP, CMD_RD_CODE, 3'h3, 8'h00, 1'h0, 8'h5A);
    cmd(SRC_API, CMD_WR_CODE, 3'h5, 8'h77, 1'h0, 8'h00);
    cmd(SRC_PAR, CMD_WR_XAF, XAF_SSB, 8'hFD, 1'h0, 8'h00);
    chk_val({13'h0000, swLevel}, {13'h0000, LVL_3});
    cmd(SRC_ISP, CMD_RD_CODE, 3'h3, 8'h00, 1'h1, 8'h00);
    cmd(SRC_PAR, CMD_RD_REF, 3'h1, 8'h00, 1'h0, REFS[1]);
    cmd(SRC_ISP, CMD_ERASE, 3'h0, 8'h00, 1'h1, 8'h00);
    cmd(SRC_PAR, CMD_ERASE, 3'h0, 8'h00, 1'h0, 8'h00);
    chk_val({15'h0000, eraseBusy}, 16'h0001);
    for (int n = 0; n < 40 && eraseBusy === 1'h1; n++)
      @(negedge mclk);
    chk_val({15'h0000, eraseBusy}, 16'h0000);
    cmd(SRC_PAR, CMD_RD_HSB, 3'h0, 8'h00, 1'h0, 8'hFF);
    cmd(SRC_PAR, CMD_RD_XAF, XAF_SSB, 8'h00, 1'h0, 8'hFF);
    cmd(SRC_API, CMD_RD_CODE, 3'h3, 8'h00, 1'h0, 8'hFF);
    cmd(SRC_PAR, CMD_WR_HSB, 3'h0, 8'hFE, 1'h0, 8'h00);
    cmd(SRC_ISP, CMD_WR_HSB, 3'h0, 8'h00, 1'h1, 8'h00);
    cmd(SRC_PAR, CMD_RD_HSB, 3'h0, 8'h00, 1'h0, 8'hFE);
    cmd(SRC_PAR, CMD_WR_XAF, 3'h3, 8'h00, 1'h1, 8'h00);
    cmd(SRC_ISP, CMD_RD_XAF, XAF_REF0, 8'h00, 1'h0, REFS[0]);
    chk_val({13'h0000, hwLevel}, {13'h0000, LVL_4});
    cmd(SRC_PAR, CMD_WR_CODE, 3'h3, 8'h5A, 1'h1, 8'h00);
    do_reset(1'h0);
    fetch(4'h3, 1'h0, 1'h0, 1'h0, 1'h1, 8'h00);
    complete_run();
  end
endmodule : test_flash_code_security_lock

`default_nettype wire
